/* hw/limit_reset_detect.v */
// Purpose: Selects a peripheral reset source and detects enabled events
// Assumes: Sources are synchronous to the core clock
// Notes:   Codes 6 and 7 are reserved inputs tied low; falling-event settings can still fire on them
`include "period_timer_regs.vh"

module limit_reset_detect (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire [5:0] src_i,
  input  wire [7:0] cfg_i,
  output wire       event_o
);

  reg  src_prev_reg;
  wire sel_src;
  wire rise_hit;
  wire fall_hit;
  wire [7:0] padded;

  // Two reserved inputs tie low [RULE10]
  assign padded  = {2'b00, src_i};
  assign sel_src = padded[cfg_i[`CFG_SRC_HI:`CFG_SRC_LO]];

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      src_prev_reg <= 1'b0;
    else
      src_prev_reg <= sel_src;
  end

  // Edge or level sensitivity per polarity [RULE9]
  assign rise_hit = cfg_i[`CFG_RISE_EN] &&
                    (cfg_i[`CFG_RISE_EDGE] ? (sel_src && !src_prev_reg)
                                           : sel_src);
  assign fall_hit = cfg_i[`CFG_FALL_EN] &&
                    (cfg_i[`CFG_FALL_EDGE] ? (!sel_src && src_prev_reg)
                                           : !sel_src);
  assign event_o = rise_hit || fall_hit;

endmodule

/* hw/period_timer.v */
// Purpose: 8-bit period timer with postscaler and hardware limit reset
// Assumes: Register port strobes are one cycle, never both at once
// Notes:   Read data stand only in the cycle after the read strobe
`include "period_timer_regs.vh"

// Functional notes
// [RULE1] Control bits 6..3 pick postscale 1:(n+1), from 1:1 to 1:16.
// [RULE2] Control bit 2 runs the timer when one, stops it when zero.
// [RULE3] Control bits 1..0 pick prescale; 00 divides by 1, 11 by 64.
// [RULE4] Prescale code 01 divides by 4, code 10 divides by 16.
// [RULE5] Control bit 7 reads zero and ignores writes.
// [RULE6] Postscaler expiry sets a flag; a separate enable gates the interrupt.
// [RULE7] Counter and period are 8-bit readable and writable registers.
// [RULE8] Limit variant keeps all base prescale and postscale ratios.
// [RULE9] Limit variant clears the counter on selected rising/falling events.
// [RULE10] Eight reset source choices, two reserved with no source.
// [RULE11] A reset event before the match restarts counting, output stays low.
// [RULE12] Without a reset event the match drives the limit output active.
// [RULE13] Prescaler is fed by the instruction clock, a quarter of the core.
// [RULE14] On match the counter returns to 00h next increment; postscaler steps.
// [RULE15] Counter or control writes clear prescaler and postscaler only.
// [RULE16] Reset sets counter to 00h and period to FFh.
module period_timer (
  input  wire                CORE_CLK_I,
  input  wire                RST_B_I,
  input  wire [`ADDR_W-1:0]  ADDR_I,
  input  wire [7:0]          WDATA_I,
  input  wire                WR_I,
  input  wire                RD_I,
  input  wire [5:0]          RESET_SRC_I,
  output reg  [7:0]          RDATA_O,
  output reg                 LIMIT_MATCH_O,
  output wire                IRQ_O
);

  reg  [7:0] control_reg;
  reg  [7:0] count_reg;
  reg  [7:0] period_reg;
  reg  [7:0] limit_cfg_reg;
  reg  [7:0] status_reg;
  reg  [7:0] mask_reg;
  reg  [3:0] post_cnt_reg;
  reg        ext_pend_reg;
  reg  [7:0] rdata_next;
  reg  [7:0] status_next;

  wire       tick;
  wire       ext_event;
  wire       match;
  wire       post_expire;
  wire       wr_ctl;
  wire       wr_cnt;
  wire       scaler_clear;
  wire [3:0] post_sel;

  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  assign wr_ctl       = WR_I && hit(ADDR_I, `ADDR_CONTROL);
  assign wr_cnt       = WR_I && hit(ADDR_I, `ADDR_COUNT);
  assign scaler_clear = wr_ctl || wr_cnt;                        // [RULE15]
  assign post_sel     = control_reg[`CTL_POST_HI:`CTL_POST_LO];

  tick_prescaler u_pre (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .clear_i (scaler_clear),
    .run_i   (control_reg[`CTL_RUN_BIT]),                        // [RULE2]
    .sel_i   (control_reg[`CTL_PRE_HI:`CTL_PRE_LO]),
    .tick_o  (tick)
  );

  limit_reset_detect u_det (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .src_i   (RESET_SRC_I),
    .cfg_i   (limit_cfg_reg),
    .event_o (ext_event)
  );

  assign match       = (count_reg == period_reg) && !ext_pend_reg;
  assign post_expire = tick && match && (post_cnt_reg == post_sel); // [RULE1]

  // Pending reset is applied on the next timer clock; a counter write wins
  // An event on a tick clears the counter at once, so it must not pend too
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      ext_pend_reg <= 1'b0;
    else if (wr_cnt)
      ext_pend_reg <= 1'b0;
    else if (tick)
      ext_pend_reg <= 1'b0;
    else if (ext_event)
      ext_pend_reg <= 1'b1;                                      // [RULE9]
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      count_reg <= `COUNT_RST;                                   // [RULE16]
    end else if (wr_cnt) begin
      count_reg <= WDATA_I;                                      // [RULE7]
    end else if (tick) begin
      if (ext_pend_reg || ext_event)
        count_reg <= `COUNT_RST;                                 // [RULE11]
      else if (count_reg == period_reg)
        count_reg <= `COUNT_RST;                                 // [RULE14]
      else
        count_reg <= count_reg + 8'h01;
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      post_cnt_reg <= 4'h0;
    else if (scaler_clear)
      post_cnt_reg <= 4'h0;                                      // [RULE15]
    else if (tick && match)
      post_cnt_reg <= (post_cnt_reg == post_sel) ? 4'h0
                                                 : post_cnt_reg + 4'h1;
  end

  // Unscaled limit output, registered for a clean data output
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      LIMIT_MATCH_O <= 1'b0;
    else
      LIMIT_MATCH_O <= match && !ext_event;                     // [RULE12]
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      control_reg   <= `ZERO8;
      period_reg    <= `PERIOD_RST;                              // [RULE16]
      limit_cfg_reg <= `ZERO8;
      mask_reg      <= `ZERO8;
    end else if (WR_I) begin
      if (hit(ADDR_I, `ADDR_CONTROL))
        control_reg <= WDATA_I & `CTL_WMASK;                     // [RULE5]
      if (hit(ADDR_I, `ADDR_PERIOD))
        period_reg <= WDATA_I;                                   // [RULE7]
      if (hit(ADDR_I, `ADDR_LIMIT_CFG))
        limit_cfg_reg <= WDATA_I & `CFG_WMASK;
      if (hit(ADDR_I, `ADDR_IRQ_MASK))
        mask_reg <= WDATA_I & `IRQ_WMASK;                        // [RULE6]
    end
  end

  // Sticky flags: write one clears, a same-cycle event wins
  always @* begin
    status_next = status_reg;
    if (WR_I && hit(ADDR_I, `ADDR_IRQ_STATUS))
      status_next = status_reg & ~(WDATA_I & `IRQ_WMASK);
    if (post_expire)
      status_next[`IRQ_MATCH_BIT] = 1'b1;                        // [RULE6]
    if (match && !ext_event && tick)
      status_next[`IRQ_LIMIT_BIT] = 1'b1;
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      status_reg <= `ZERO8;
    else
      status_reg <= status_next;
  end

  assign IRQ_O = |(status_reg & mask_reg);                       // [RULE6]

  always @* begin
    case (ADDR_I)
      `ADDR_CONTROL:    rdata_next = control_reg;                // [RULE5]
      `ADDR_COUNT:      rdata_next = count_reg;
      `ADDR_PERIOD:     rdata_next = period_reg;
      `ADDR_LIMIT_CFG:  rdata_next = limit_cfg_reg;
      `ADDR_IRQ_STATUS: rdata_next = status_reg;
      `ADDR_IRQ_MASK:   rdata_next = mask_reg;
      default:          rdata_next = `ZERO8;
    endcase
  end

  // Read data valid only the cycle after the strobe, zero otherwise
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      RDATA_O <= `ZERO8;
    else if (RD_I)
      RDATA_O <= rdata_next;
    else
      RDATA_O <= `ZERO8;
  end

endmodule

/* hw/period_timer_regs.vh */
// Purpose: Register map, field positions and reset values of the period timer
// Assumes: Byte-wide registers on a plain strobe port, word index addressing
// Notes:   Definitions only
`ifndef PERIOD_TIMER_REGS_VH
`define PERIOD_TIMER_REGS_VH

`define ADDR_W            3
`define ADDR_CONTROL      3'h0
`define ADDR_COUNT        3'h1
`define ADDR_PERIOD       3'h2
`define ADDR_LIMIT_CFG    3'h3
`define ADDR_IRQ_STATUS   3'h4
`define ADDR_IRQ_MASK     3'h5

`define CTL_POST_HI       6
`define CTL_POST_LO       3
`define CTL_RUN_BIT       2
`define CTL_PRE_HI        1
`define CTL_PRE_LO        0
`define CTL_WMASK         8'h7f

`define CFG_SRC_HI        2
`define CFG_SRC_LO        0
`define CFG_RISE_EN       3
`define CFG_FALL_EN       4
`define CFG_RISE_EDGE     5
`define CFG_FALL_EDGE     6
`define CFG_WMASK         8'h7f

`define IRQ_MATCH_BIT     0
`define IRQ_LIMIT_BIT     1
`define IRQ_WMASK         8'h03

`define COUNT_RST         8'h00
`define PERIOD_RST        8'hff
`define ZERO8             8'h00

`define PRE_DIV1          2'h0
`define PRE_DIV4          2'h1
`define PRE_DIV16         2'h2
`define PRE_DIV64         2'h3
`define PRE_TC1           6'h00
`define PRE_TC4           6'h03
`define PRE_TC16          6'h0f
`define PRE_TC64          6'h3f
`define INSTR_DIV_TC      2'h3

`endif

/* hw/tick_prescaler.v */
// Purpose: Instruction clock divider and selectable timer prescaler
// Assumes: Core clock stands in for the oscillator
// Notes:   Emits one-cycle enable pulses only
`include "period_timer_regs.vh"

module tick_prescaler (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire       clear_i,
  input  wire       run_i,
  input  wire [1:0] sel_i,
  output wire       tick_o
);

  reg  [1:0] instr_cnt_reg;
  reg  [5:0] pre_cnt_reg;
  reg  [5:0] tc;
  wire       instr_tick;

  // Instruction clock runs at a quarter of the core rate [RULE13]
  assign instr_tick = (instr_cnt_reg == `INSTR_DIV_TC);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      instr_cnt_reg <= 2'h0;
    else
      instr_cnt_reg <= instr_cnt_reg + 2'h1;
  end

  always @* begin
    case (sel_i)                                     // [RULE3] [RULE4] [RULE8]
      `PRE_DIV1:  tc = `PRE_TC1;
      `PRE_DIV4:  tc = `PRE_TC4;
      `PRE_DIV16: tc = `PRE_TC16;
      default:    tc = `PRE_TC64;
    endcase
  end

  assign tick_o = run_i && instr_tick && (pre_cnt_reg >= tc);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      pre_cnt_reg <= 6'h00;
    else if (clear_i)
      pre_cnt_reg <= 6'h00;                          // [RULE15]
    else if (run_i && instr_tick)
      pre_cnt_reg <= (pre_cnt_reg >= tc) ? 6'h00 : pre_cnt_reg + 6'h01;
  end

endmodule

/* testbench/period_timer_props.sv */
// Purpose: Port-level properties of the period timer
// Assumes: Accesses leave one idle cycle between strobes
// Notes:   Bound to the design from the bench top file
module period_timer_props (
  input wire       CORE_CLK_I,
  input wire       RST_B_I,
  input wire [2:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       RD_I,
  input wire [7:0] RDATA_O,
  input wire       IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  rd_idle_a: assert property (
    !$past(RD_I) |-> RDATA_O == 8'h00) else $error("read data out of slot");
  ctl_rdback_a: assert property (
    WR_I && ADDR_I == 3'h0 ##2 RD_I && ADDR_I == 3'h0
    |=> RDATA_O == ($past(WDATA_I, 3) & 8'h7f)) else $error("control back");
  top_bit_a: assert property (
    $past(RD_I) && $past(ADDR_I) == 3'h0 |-> !RDATA_O[7])
    else $error("control bit 7 set");
  unmapped_rd_a: assert property (
    $past(RD_I) && $past(ADDR_I) > 3'h5 |-> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  period_rdback_a: assert property (
    WR_I && ADDR_I == 3'h2 ##2 RD_I && ADDR_I == 3'h2
    |=> RDATA_O == $past(WDATA_I, 3)) else $error("period readback");
  count_rdback_a: assert property (
    WR_I && ADDR_I == 3'h1 ##2 RD_I && ADDR_I == 3'h1
    |=> (RDATA_O - $past(WDATA_I, 3)) <= 8'h01 || RDATA_O == 8'h00)
    else $error("count readback");
  mask_off_a: assert property (
    WR_I && ADDR_I == 3'h5 && WDATA_I[1:0] == 2'h0 |=> !IRQ_O)
    else $error("irq with mask clear");
  status_rsvd_a: assert property (
    $past(RD_I) && $past(ADDR_I) == 3'h4 |-> RDATA_O[7:2] == 6'h00)
    else $error("status spare bits set");
endmodule

/* testbench/period_timer_with_hw_limit_test.sv */
// Purpose: Register-level test of the period timer
// Assumes: Core clock 4 ns, free-running instruction divide by 4
// Notes:   Timing checks allow one tick of divider phase
module period_timer_with_hw_limit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [5:0] src = 6'h00;
  wire  [7:0] rdata;
  wire        limit;
  wire        irq;
  logic [7:0] v;
  int         err_total = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n;
  int         hits;
  always #2 clk = ~clk;
  period_timer i_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RESET_SRC_I(src),
    .RDATA_O(rdata), .LIMIT_MATCH_O(limit), .IRQ_O(irq));
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Counts cycles in which the limit output is seen high
  task automatic watch(input int k);
    hits = 0;
    repeat (k) begin
      @(posedge clk);
      #1;
      if (limit === 1'b1) hits++;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(3'h1, v);
    chk("count reset", 8'h00, v);
    rd_reg(3'h2, v);
    chk("period reset", 8'hff, v);
    wr_reg(3'h0, 8'hff);
    rd_reg(3'h0, v);
    chk("control bits", 8'h7f, v);
    rd_reg(3'h7, v);
    chk("unmapped", 8'h00, v);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h2, 8'h3c);
    rd_reg(3'h2, v);
    chk("period rw", 8'h3c, v);
    wr_reg(3'h1, 8'h5a);
    rd_reg(3'h1, v);
    chk("count rw", 8'h5a, v);
    repeat (40) @(posedge clk);
    rd_reg(3'h1, v);
    chk("stopped count", 8'h5a, v);
    $display("test registers done");
    // Wait is one divider period short so phase slip cannot add a step
    for (int c = 0; c < 4; c++) begin
      wr_reg(3'h1, 8'h00);
      wr_reg(3'h0, {6'h01, c[1:0]});
      repeat ((12 << (2 * c)) - 4) @(posedge clk);
      rd_reg(3'h1, v);
      wr_reg(3'h0, 8'h00);
      chk("prescale", 8'h01, {7'h00, v == 8'h02 || v == 8'h03});
    end
    $display("test prescale done");
    wr_reg(3'h2, 8'h03);
    wr_reg(3'h5, 8'h01);
    for (int p = 0; p < 16; p += 5) begin
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h4, 8'h03);
      rd_reg(3'h4, v);
      chk("status clear", 8'h00, v);
      wr_reg(3'h1, 8'h00);
      wr_reg(3'h0, {1'b0, p[3:0], 3'h4});
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge clk);
        #1 n++;
      end
      chk("postscale", 8'h01,
          {7'h00, n > 16 * p + 8 && n <= 16 * p + 24});
      rd_reg(3'h1, v);
      chk("wrap", 8'h00, v);
    end
    wr_reg(3'h5, 8'h00);
    rd_reg(3'h4, v);
    chk("masked irq", 8'h00, {7'h00, irq});
    chk("sticky flag", 8'h01, v & 8'h01);
    $display("test postscale done");
    wr_reg(3'h2, 8'h08);
    wr_reg(3'h3, 8'h15);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h0, 8'h04);
    watch(200);
    chk("fall level held", 8'h00, hits[7:0]);
    wr_reg(3'h4, 8'h03);
    wr_reg(3'h3, 8'h08);
    src <= 6'h01;
    watch(200);
    chk("rise level held", 8'h00, hits[7:0]);
    rd_reg(3'h4, v);
    chk("no limit flag", 8'h00, v & 8'h02);
    src <= 6'h00;
    watch(60);
    chk("limit active", 8'h01, {7'h00, hits > 0});
    rd_reg(3'h4, v);
    chk("limit flag", 8'h02, v & 8'h02);
    wr_reg(3'h3, 8'h28);
    wr_reg(3'h1, 8'h00);
    repeat (2) @(posedge clk);
    n = 0;
    for (int i = 0; i < 10; i++) begin
      src <= 6'h01;
      watch(1);
      n += hits;
      src <= 6'h00;
      watch(15);
      n += hits;
    end
    chk("edge reset", 8'h00, n[7:0]);
    // A held level must not keep an edge-sensitive reset active
    src <= 6'h01;
    watch(60);
    chk("edge not held", 8'h01, {7'h00, hits > 0});
    wr_reg(3'h3, 8'h0e);
    src <= 6'h3f;
    watch(60);
    chk("reserved source", 8'h01, {7'h00, hits > 0});
    $display("test limit done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(3'h2, v);
    chk("period after reset", 8'hff, v);
    rd_reg(3'h1, v);
    chk("count after reset", 8'h00, v);
    chk("limit after reset", 8'h00, {7'h00, limit});
    $display("test reset done");
    end_of_test();
  end
endmodule
bind period_timer period_timer_props i_props (.CORE_CLK_I(CORE_CLK_I),
  .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O));
